// ==== irqc_pkg.sv ====
// Package with constants, register map and carrier types of the interrupt controller.
package irqc_pkg;

	// Source layout: external pins first, then port change, then peripherals.
	localparam int unsigned N_SRC        = 8;
	localparam int unsigned N_EXT        = 4;
	localparam int unsigned N_PORT       = 4;
	localparam int unsigned SRC_PORT     = 4;
	localparam int unsigned FIRST_PERIPH = 5;
	localparam int unsigned N_PERIPH     = N_SRC - FIRST_PERIPH;

	// Byte offsets of the registers on the bus.
	localparam logic [7:0] OFS_RESET_CTRL = 8'h00;
	localparam logic [7:0] OFS_IRQ_CTRL   = 8'h04;
	localparam logic [7:0] OFS_FLAGS      = 8'h08;
	localparam logic [7:0] OFS_ENABLES    = 8'h0c;
	localparam logic [7:0] OFS_PRIORITY   = 8'h10;
	localparam logic [7:0] OFS_EDGE_SEL   = 8'h14;
	localparam logic [7:0] OFS_STATUS     = 8'h18;

	// Field positions.
	localparam int unsigned BIT_PRIO_MODE = 7;
	localparam int unsigned BIT_HIGH_EN   = 7;
	localparam int unsigned BIT_LOW_EN    = 6;
	localparam int unsigned BIT_HI_ACT    = 0;
	localparam int unsigned BIT_LO_ACT    = 1;
	localparam int unsigned BIT_REQ       = 2;

	// Values after reset.
	localparam logic [N_SRC-1:0] RST_PRIORITY = 8'hff;
	localparam logic [N_EXT-1:0] RST_EDGE_SEL = 4'hf;

	// Vector addresses.
	localparam logic [15:0] VEC_HIGH = 16'h0008;
	localparam logic [15:0] VEC_LOW  = 16'h0018;

	// Instruction cycle and latency.
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned INSTR_CYCLE_NS = 20;
	localparam int unsigned CYC_CLKS = INSTR_CYCLE_NS / CLK_PERIOD_NS;
	localparam logic [7:0] CYC_LAST = 8'(CYC_CLKS - 1);
	localparam logic [1:0] LAT_TICKS = 2'h2;

	// Bus request from the Avalon master.
	typedef struct packed {
		logic        read;
		logic        write;
		logic [7:0]  address;
		logic [31:0] writedata;
	} avm_req_s;

	// Entry information handed to the core.
	typedef struct packed {
		logic        entry;
		logic [15:0] vector;
		logic        req;
	} core_irq_s;

endpackage

// ==== pin_sync_edge.sv ====
// Two-flop synchroniser with selectable edge detector for pin inputs.
`timescale 1ns/1ps
module pin_sync_edge #(
	parameter int unsigned W = 4
) (
	// Clock and reset.
	input  wire logic         clk_sys,
	input  wire logic         srst,
	// Pins and edge choice.
	input  wire logic [W-1:0] pin_in,
	input  wire logic [W-1:0] edge_sel,
	// Synchronised level and edge pulses.
	output logic [W-1:0]      level,
	output logic [W-1:0]      edge_evt
);
	// Whole state: metastable stage, settled stage and previous level.
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
		logic [W-1:0] prev;
	} sync_s;

	sync_s st_r;
	sync_s st_nxt;

	// Shift the pins through; only the second and third stages drive the outputs.
	always_comb begin
		st_nxt      = st_r;
		st_nxt.meta = pin_in;
		st_nxt.sync = st_r.meta;
		st_nxt.prev = st_r.sync;
	end

	// Synchronous reset clears every stage to the idle low level.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Select 1 flags a rising edge, 0 a falling edge.
	assign level    = st_r.sync;
	assign edge_evt = (edge_sel & st_r.sync & ~st_r.prev) |
		(~edge_sel & ~st_r.sync & st_r.prev);

endmodule // pin_sync_edge

// ==== irq_controller.sv ====
// Two-level interrupt controller with Avalon-MM register access.
//
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module irq_controller
	import irqc_pkg::*;
(
	// Clock and reset.
	input  wire logic                   clk_sys,
	input  wire logic                   srst,
	// Avalon-MM slave.
	input  wire irqc_pkg::avm_req_s     avs_req,
	output logic [31:0]                 avs_readdata,
	output logic                        avs_waitrequest,
	// Interrupt sources.
	input  wire logic [irqc_pkg::N_EXT-1:0]    ext_pin,
	input  wire logic [irqc_pkg::N_PORT-1:0]   port_pin,
	input  wire logic                          port_read,
	input  wire logic [irqc_pkg::N_PERIPH-1:0] periph_evt,
	// Core side.
	input  wire logic                   return_from_irq_instr,
	output irqc_pkg::core_irq_s         core_irq
);
	import irqc_pkg::*;

	// Whole state of the controller.
	typedef struct packed {
		logic             priority_mode_enable;
		logic             high_group_enable;
		logic             low_group_enable;
		logic [N_SRC-1:0] flag;
		logic [N_SRC-1:0] enable;
		logic [N_SRC-1:0] prio;
		logic [N_EXT-1:0] edge_sel;
		logic [N_PORT-1:0] port_latch;
		logic             hi_act;
		logic             lo_act;
		logic [7:0]       div;
		logic [1:0]       lat;
		logic             entry;
		logic [15:0]      vector;
		logic             req;
		logic             waitreq;
		logic [31:0]      rdata;
	} state_s;

	state_s s_r;
	state_s s_nxt;

	logic [N_EXT-1:0]  ext_edge;
	logic [N_PORT-1:0] port_lvl;
	logic [N_SRC-1:0]  set_evt;
	logic [N_SRC-1:0]  active;
	logic [N_SRC-1:0]  periph_mask;
	logic              mismatch;
	logic              tick;
	logic              hi_req;
	logic              lo_req;
	logic              bus_req;
	logic              accept;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers.

	// External pins with edge detection.
	pin_sync_edge #(.W(N_EXT)) u_ext_sync (
		.clk_sys  (clk_sys),
		.srst     (srst),
		.pin_in   (ext_pin),
		.edge_sel (s_r.edge_sel),
		.level    (),
		.edge_evt (ext_edge)
	);

	// Port-change pins need only the level.
	pin_sync_edge #(.W(N_PORT)) u_port_sync (
		.clk_sys  (clk_sys),
		.srst     (srst),
		.pin_in   (port_pin),
		.edge_sel (s_r.port_latch),
		.level    (port_lvl),
		.edge_evt ()
	);

	////////////////////////////////////////////////////////////////////////
	// Event and request decoding.

	// A mismatch against the last read value keeps raising the flag.
	assign mismatch = port_lvl != s_r.port_latch;
	assign set_evt  = {periph_evt, mismatch, ext_edge};
	assign active   = s_r.flag & s_r.enable;
	assign periph_mask = {{N_PERIPH{1'b1}}, {FIRST_PERIPH{1'b0}}};
	assign tick     = s_r.div == CYC_LAST;
	assign bus_req  = avs_req.read | avs_req.write;
	assign accept   = bus_req & ~s_r.waitreq;

	// Group gating; the low group also needs the high enable set.
	always_comb begin
		if (s_r.priority_mode_enable) begin
			hi_req = s_r.high_group_enable &
				(|(active & s_r.prio));
			lo_req = s_r.high_group_enable & s_r.low_group_enable &
				(|(active & ~s_r.prio));
			// A running high service holds off every low request.
			lo_req = lo_req & ~s_r.hi_act;
		end else begin
			hi_req = s_r.high_group_enable & (|(active & ~periph_mask) |
				(s_r.low_group_enable & |(active & periph_mask)));
			lo_req = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	// Register file, service tracking and entry sequencing.
	always_comb begin
		s_nxt       = s_r;
		s_nxt.entry = 1'b0;
		s_nxt.div   = tick ? 8'h00 : s_r.div + 8'h01;
		s_nxt.req   = hi_req | lo_req;

		// Bus handshake: one wait cycle, then the access completes.
		s_nxt.waitreq = ~(bus_req & s_r.waitreq);
		if (bus_req & s_r.waitreq) begin
			s_nxt.rdata = 32'h0000_0000;
			case (avs_req.address)
			OFS_RESET_CTRL: s_nxt.rdata[BIT_PRIO_MODE] =
				s_r.priority_mode_enable;
			OFS_IRQ_CTRL: begin
				s_nxt.rdata[BIT_HIGH_EN] = s_r.high_group_enable;
				s_nxt.rdata[BIT_LOW_EN]  = s_r.low_group_enable;
			end
			OFS_FLAGS:    s_nxt.rdata[N_SRC-1:0] = s_r.flag;
			OFS_ENABLES:  s_nxt.rdata[N_SRC-1:0] = s_r.enable;
			OFS_PRIORITY: s_nxt.rdata[N_SRC-1:0] = s_r.prio;
			OFS_EDGE_SEL: s_nxt.rdata[N_EXT-1:0] = s_r.edge_sel;
			OFS_STATUS: begin
				s_nxt.rdata[BIT_HI_ACT] = s_r.hi_act;
				s_nxt.rdata[BIT_LO_ACT] = s_r.lo_act;
				s_nxt.rdata[BIT_REQ]    = s_r.req;
			end
			default: s_nxt.rdata = 32'h0000_0000;
			endcase
		end

		// Software writes; unmapped addresses are ignored.
		if (accept & avs_req.write) begin
			case (avs_req.address)
			OFS_RESET_CTRL: s_nxt.priority_mode_enable =
				avs_req.writedata[BIT_PRIO_MODE];
			OFS_IRQ_CTRL: begin
				s_nxt.high_group_enable = avs_req.writedata[BIT_HIGH_EN];
				s_nxt.low_group_enable  = avs_req.writedata[BIT_LOW_EN];
			end
			OFS_FLAGS:    s_nxt.flag = avs_req.writedata[N_SRC-1:0];
			OFS_ENABLES:  s_nxt.enable = avs_req.writedata[N_SRC-1:0];
			OFS_PRIORITY: s_nxt.prio = avs_req.writedata[N_SRC-1:0];
			OFS_EDGE_SEL: s_nxt.edge_sel = avs_req.writedata[N_EXT-1:0];
			default: s_nxt.flag = s_nxt.flag;
			endcase
		end

		// Events win over a software clear in the same cycle.
		s_nxt.flag = s_nxt.flag | set_evt;

		// A port read takes a new reference, ending the mismatch.
		if (port_read) begin
			s_nxt.port_latch = port_lvl;
		end

		// Return from interrupt re-opens the group that was serviced.
		if (return_from_irq_instr) begin
			if (s_r.priority_mode_enable & s_r.hi_act) begin
				s_nxt.hi_act            = 1'b0;
				s_nxt.high_group_enable = 1'b1;
			end else if (s_r.priority_mode_enable) begin
				s_nxt.lo_act           = 1'b0;
				s_nxt.low_group_enable = 1'b1;
			end else begin
				s_nxt.hi_act            = 1'b0;
				s_nxt.high_group_enable = 1'b1;
			end
		end

		// Latency counter: a request must persist over instruction cycles.
		if (tick) begin
			if (!(hi_req | lo_req)) begin
				s_nxt.lat = 2'h0;
			end else if (s_r.lat != LAT_TICKS) begin
				s_nxt.lat = s_r.lat + 2'h1;
			end else begin
				s_nxt.lat   = 2'h0;
				s_nxt.entry = 1'b1;
				// Compatibility mode only ever reaches the high branch.
				if (hi_req) begin
					// High wins and may break into a low service.
					s_nxt.vector            = VEC_HIGH;
					s_nxt.hi_act            = 1'b1;
					s_nxt.high_group_enable = 1'b0;
				end else begin
					s_nxt.vector           = VEC_LOW;
					s_nxt.lo_act           = 1'b1;
					s_nxt.low_group_enable = 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register.

	// Synchronous reset to the documented defaults.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			s_r                      <= '0;
			s_r.prio                 <= RST_PRIORITY;
			s_r.edge_sel             <= RST_EDGE_SEL;
			s_r.waitreq              <= 1'b1;
			s_r.vector               <= VEC_HIGH;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs come straight from the state register.
	assign avs_readdata    = s_r.rdata;
	assign avs_waitrequest = s_r.waitreq;
	assign core_irq.entry  = s_r.entry;
	assign core_irq.vector = s_r.vector;
	assign core_irq.req    = s_r.req;

	////////////////////////////////////////////////////////////////////////
	// Checks.

	chk_compat_vector: assert property (
		@(posedge clk_sys) disable iff (srst)
		s_r.entry && !s_r.priority_mode_enable |-> s_r.vector == VEC_HIGH)
		else $error("compatibility entry not at high vector");

	chk_high_entry_clear: assert property (
		@(posedge clk_sys) disable iff (srst)
		s_r.entry && s_r.vector == VEC_HIGH |->
		!s_r.high_group_enable && s_r.hi_act)
		else $error("high entry left its enable set");

	chk_low_entry_clear: assert property (
		@(posedge clk_sys) disable iff (srst)
		s_r.entry && s_r.vector == VEC_LOW |->
		!s_r.low_group_enable && s_r.lo_act)
		else $error("low entry left its enable set");

	chk_low_blocked: assert property (
		@(posedge clk_sys) disable iff (srst)
		s_r.entry && s_r.vector == VEC_LOW |-> !$past(s_r.hi_act))
		else $error("low entry during high service");

	chk_high_gated: assert property (
		@(posedge clk_sys) disable iff (srst)
		s_r.entry && s_r.vector == VEC_HIGH |->
		$past(s_r.high_group_enable, 1))
		else $error("high entry with high enable clear");

	chk_return_reopen: assert property (
		@(posedge clk_sys) disable iff (srst)
		return_from_irq_instr && !s_r.priority_mode_enable &&
		!(tick && hi_req) &&
		!(accept && avs_req.write) |=> s_r.high_group_enable && !s_r.hi_act)
		else $error("return did not reopen interrupts");

	chk_flag_sticky: assert property (
		@(posedge clk_sys) disable iff (srst)
		set_evt[0] |=> s_r.flag[0])
		else $error("pin event lost");

	chk_port_mismatch: assert property (
		@(posedge clk_sys) disable iff (srst)
		mismatch |=> s_r.flag[SRC_PORT])
		else $error("port change flag not held");

	chk_entry_on_tick: assert property (
		@(posedge clk_sys) disable iff (srst)
		s_r.entry |-> $past(tick) && $past(hi_req || lo_req))
		else $error("entry without request on instruction cycle");

	chk_bus_wait: assert property (
		@(posedge clk_sys) disable iff (srst)
		bus_req && s_r.waitreq |=> !s_r.waitreq ##1 s_r.waitreq)
		else $error("waitrequest did not drop for one cycle");

endmodule // irq_controller

// ==== core_model.sv ====
// Behavioural model of the processor core that takes interrupt entries.
`timescale 1ns/1ps
module core_model
	import irqc_pkg::*;
(
	// Clock and reset.
	input  wire logic                clk_sys,
	input  wire logic                srst,
	// Controller side.
	input  wire irqc_pkg::core_irq_s core_irq,
	output logic                     return_from_irq_instr,
	// Bench side.
	input  wire logic                ret_go,
	output logic [15:0]              pc_r,
	output logic [3:0]               depth_r
);
	// Entry pushes and loads the vector; a return pops one level.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pc_r                  <= 16'h0100;
			depth_r               <= 4'h0;
			return_from_irq_instr <= 1'b0;
		end else begin
			return_from_irq_instr <= ret_go;
			if (core_irq.entry) begin
				pc_r    <= core_irq.vector;
				depth_r <= depth_r + 4'h1;
			end else if (ret_go) begin
				depth_r <= depth_r - 4'h1;
			end
		end
	end
endmodule // core_model

// ==== tb_top.sv ====
// Self-checking testbench for the two-level interrupt controller.
`timescale 1ns/1ps
module tb_top;
	import irqc_pkg::*;

	logic                clk_sys;
	logic                srst;
	avm_req_s            avs_req;
	logic [31:0]         avs_readdata;
	logic                avs_waitrequest;
	logic [N_EXT-1:0]    ext_pin;
	logic [N_PORT-1:0]   port_pin;
	logic                port_read;
	logic [N_PERIPH-1:0] periph_evt;
	logic                return_from_irq_instr;
	core_irq_s           core_irq;
	logic                ret_go;
	logic [15:0]         pc_r;
	logic [3:0]          depth_r;
	int                  num_errors;
	int                  n_checks;
	int                  n;

	// Design and core model.
	irq_controller DUT (.clk_sys(clk_sys), .srst(srst), .avs_req(avs_req),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.ext_pin(ext_pin), .port_pin(port_pin), .port_read(port_read),
		.periph_evt(periph_evt), .core_irq(core_irq),
		.return_from_irq_instr(return_from_irq_instr));
	core_model core (.clk_sys(clk_sys), .srst(srst), .core_irq(core_irq),
		.return_from_irq_instr(return_from_irq_instr), .ret_go(ret_go),
		.pc_r(pc_r), .depth_r(depth_r));

	// Free-running 200 MHz clock.
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	////////////////////////////////////////////////////////////////////////////

	// Counts every comparison and reports a mismatch at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One Avalon transfer, held until waitrequest is seen low at an edge.
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int k;
		k = 0;
		avs_req <= '{read: !w, write: w, address: a, writedata: d};
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0 && k < 50) begin
			@(posedge clk_sys);
			k++;
		end
		if (k >= 50) begin
			num_errors++;
			$display("[FAIL] t=%0t bus timeout got=%h exp=%h", $time,
				avs_waitrequest, 1'b0);
		end
		q = avs_readdata;
		avs_req <= '0;
		@(posedge clk_sys);
	endtask

	// Plain register writes only; no memory-to-memory moves are modelled.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	// Read and compare against the expected word.
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask

	// Waits for an entry pulse; a count of 60 means none came.
	task automatic wait_entry(output int c);
		c = 0;
		while (core_irq.entry !== 1'b1 && c < 60) begin
			@(posedge clk_sys);
			c++;
		end
	endtask

	// One-cycle peripheral event pulse.
	task automatic evt(input logic [N_PERIPH-1:0] m);
		periph_evt <= m;
		@(posedge clk_sys);
		periph_evt <= '0;
	endtask

	// The core executes a return from interrupt.
	task automatic ret();
		ret_go <= 1'b1;
		@(posedge clk_sys);
		ret_go <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic finish_test();
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Cuts a hang short.
	initial begin
		repeat (5000) @(posedge clk_sys);
		num_errors++;
		finish_test();
	end

	// Main test sequence.
	initial begin
		num_errors = 0;
		n_checks = 0;
		srst = 1'b1;
		avs_req = '0;
		ext_pin = '0;
		port_pin = '0;
		port_read = 1'b0;
		periph_evt = '0;
		ret_go = 1'b0;
		repeat (20) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		rd(OFS_RESET_CTRL, 32'h0);
		rd(OFS_PRIORITY, 32'hff);
		rd(OFS_EDGE_SEL, 32'hf);
		rd(OFS_IRQ_CTRL, 32'h0);
		rd(8'h1c, 32'h0);
		$display("test reset values done");
		evt(3'h1);
		repeat (2) @(posedge clk_sys);
		rd(OFS_FLAGS, 32'h20);
		wr(OFS_FLAGS, 32'h0);
		ext_pin[1] <= 1'b1;
		repeat (8) @(posedge clk_sys);
		rd(OFS_FLAGS, 32'h2);
		wr(OFS_FLAGS, 32'h0);
		wr(OFS_EDGE_SEL, 32'he);
		// Pin 0 rises and pin 1 falls: neither edge is selected.
		ext_pin <= 4'h1;
		repeat (8) @(posedge clk_sys);
		rd(OFS_FLAGS, 32'h0);
		$display("test flags and edges done");
		wr(OFS_ENABLES, 32'h1);
		wr(OFS_IRQ_CTRL, 32'h80);
		ext_pin <= 4'h0;
		wait_entry(n);
		chk(32'(n >= 13 && n <= 17), 32'h1);
		chk({31'h0, core_irq.req}, 32'h1);
		chk({16'h0, core_irq.vector}, {16'h0, VEC_HIGH});
		rd(OFS_IRQ_CTRL, 32'h0);
		chk({31'h0, core_irq.req}, 32'h0);
		wr(OFS_FLAGS, 32'h0);
		ret();
		rd(OFS_IRQ_CTRL, 32'h80);
		wr(OFS_PRIORITY, 32'hdf);
		wr(OFS_ENABLES, 32'h20);
		evt(3'h1);
		wait_entry(n);
		chk(32'(n), 32'd60);
		wr(OFS_IRQ_CTRL, 32'hc0);
		wait_entry(n);
		chk(32'(n < 60), 32'h1);
		chk({16'h0, core_irq.vector}, {16'h0, VEC_HIGH});
		rd(OFS_IRQ_CTRL, 32'h40);
		wr(OFS_FLAGS, 32'h0);
		ret();
		rd(OFS_IRQ_CTRL, 32'hc0);
		$display("test compatibility mode done");
		wr(OFS_RESET_CTRL, 32'h80);
		wr(OFS_ENABLES, 32'h60);
		evt(3'h1);
		wait_entry(n);
		chk(32'(n < 60), 32'h1);
		chk({16'h0, core_irq.vector}, {16'h0, VEC_LOW});
		rd(OFS_IRQ_CTRL, 32'h80);
		evt(3'h2);
		wait_entry(n);
		chk(32'(n < 60), 32'h1);
		chk({16'h0, core_irq.vector}, {16'h0, VEC_HIGH});
		rd(OFS_STATUS, 32'h3);
		chk({28'h0, depth_r}, 32'h2);
		chk({16'h0, pc_r}, {16'h0, VEC_HIGH});
		wr(OFS_FLAGS, 32'h0);
		wr(OFS_IRQ_CTRL, 32'hc0);
		evt(3'h1);
		wait_entry(n);
		chk(32'(n), 32'd60);
		wr(OFS_FLAGS, 32'h0);
		ret();
		rd(OFS_STATUS, 32'h2);
		ret();
		rd(OFS_STATUS, 32'h0);
		$display("test priority mode done");
		port_pin <= 4'h1;
		repeat (8) @(posedge clk_sys);
		rd(OFS_FLAGS, 32'h10);
		wr(OFS_FLAGS, 32'h0);
		rd(OFS_FLAGS, 32'h10);
		port_read <= 1'b1;
		@(posedge clk_sys);
		port_read <= 1'b0;
		repeat (8) @(posedge clk_sys);
		wr(OFS_FLAGS, 32'h0);
		rd(OFS_FLAGS, 32'h0);
		$display("test port change done");
		finish_test();
	end
endmodule // tb_top
